/* hdl/ldm_pkg.sv */
// constants, field layout and carriers for the link latency register bank
// assumes an apb slave on sys_clk with byte addresses of 8 bits
package ldm_pkg;
    localparam int RX_BUF_DEPTH = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_RX_LATENCY = 8'h4c;
    localparam logic [ADDR_W-1:0] ADDR_TX_EXT = 8'h50;
    localparam logic [ADDR_W-1:0] ADDR_RX_EXT = 8'h54;
    localparam logic [ADDR_W-1:0] ADDR_LOOP = 8'h58;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h70;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h74;
    localparam int REALIGN_BIT = 24;
    localparam int BYTE_ALIGN_BIT = 16;
    localparam int SPAN_LSB = 24;
    localparam int SPAN_W = 8;
    localparam int FRESH_BIT = 23;
    localparam int TX_EXT_W = 16;
    localparam int LOOP_W = 20;
    localparam logic [LOOP_W-1:0] LOOP_MAX = 20'hfffff;
    localparam logic [LOOP_W-1:0] LOOP_FIRST = 20'h00001;
    localparam logic [RX_BUF_DEPTH-1:0] FILL_MAX = 4'hf;
    localparam int IRQ_TX = 0;
    localparam int IRQ_RX = 1;
    localparam int IRQ_LOOP = 2;
    localparam int IRQ_RESYNC = 3;
    localparam int IRQ_W = 4;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [SPAN_W-1:0] SPAN_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic pwrite;
        logic [DATA_W-1:0] pwdata;
        logic psel;
        logic penable;
    } ldm_apb_req_type;

    typedef struct packed {
        logic strobe;
        logic [TX_EXT_W-1:0] value;
    } ldm_ext_result_type;
endpackage

/* hdl/ldm_sync.sv */
// three-stage synchroniser for a pin level
// assumes a slowly changing level from outside the sys_clk domain
`timescale 1ns/1ps
module ldm_sync (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic pin_in,
    output logic level
);
    logic ff1;
    logic ff2;
    logic ff3;

    // ff1 feeds ff2 only
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            ff1 <= 1'b0;
            ff2 <= 1'b0;
            ff3 <= 1'b0;
        end
        else
        begin
            ff1 <= pin_in;
            ff2 <= ff1;
            ff3 <= ff2;
        end
    end

    // a change counts once two stages agree
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            level <= 1'b0;
        else if (ff2 == ff3)
            level <= ff3;
    end
endmodule

/* hdl/ldm_loop_counter.sv */
// counts sys_clk periods from tx frame pulse to rx frame pulse
// assumes synchronised, same-clock frame levels
`timescale 1ns/1ps
module ldm_loop_counter (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic tx_frame,
    input wire logic rx_frame,
    output logic [ldm_pkg::LOOP_W-1:0] result,
    output logic done
);
    typedef enum logic {LDM_IDLE, LDM_RUN} ldm_loop_state_type;
    ldm_loop_state_type state;
    logic tx_prev;
    logic rx_prev;
    logic tx_rise;
    logic rx_rise;
    logic [ldm_pkg::LOOP_W-1:0] count;

    assign tx_rise = tx_frame & ~tx_prev;
    assign rx_rise = rx_frame & ~rx_prev;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            tx_prev <= 1'b0;
            rx_prev <= 1'b0;
        end
        else
        begin
            tx_prev <= tx_frame;
            rx_prev <= rx_frame;
        end
    end

    // one measurement per radio frame; a new tx pulse restarts it
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            state <= LDM_IDLE;
            count <= '0;
            result <= '0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            case (state)
                LDM_IDLE:
                begin
                    if (tx_rise)
                    begin
                        // start at one so the stored count equals the edge spacing
                        count <= ldm_pkg::LOOP_FIRST;
                        state <= LDM_RUN;
                    end
                end
                LDM_RUN:
                begin
                    if (rx_rise)
                    begin
                        result <= count;
                        done <= 1'b1;
                        state <= LDM_IDLE;
                    end
                    else if (tx_rise)
                        count <= ldm_pkg::LOOP_FIRST;
                    else if (count != ldm_pkg::LOOP_MAX)
                        count <= count + 1'b1;
                end
                default:
                    state <= LDM_IDLE;
            endcase
        end
    end
endmodule

/* hdl/ldm_regs.sv */
// apb register bank for link latency status and control
// assumes datapath inputs on sys_clk; frame pulses arrive from pins
`timescale 1ns/1ps
module ldm_regs (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire ldm_pkg::ldm_apb_req_type apb_req,
    output logic [ldm_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ldm_pkg::RX_BUF_DEPTH:0] rx_fill_level,
    input wire logic rx_byte_align,
    input wire logic rate_change,
    input wire ldm_pkg::ldm_ext_result_type tx_result,
    input wire ldm_pkg::ldm_ext_result_type rx_result,
    input wire logic aux_tx_frame,
    input wire logic aux_rx_frame,
    output logic rx_ptr_resync,
    output logic [ldm_pkg::SPAN_W-1:0] tx_integration_span,
    output logic [ldm_pkg::SPAN_W-1:0] rx_integration_span,
    output logic irq
);
    logic setup;
    logic access;
    logic wr;
    logic rd_setup;
    logic rd_access;
    logic [ldm_pkg::ADDR_W-1:0] addr;
    logic [ldm_pkg::DATA_W-1:0] wdata;
    logic rx_pointer_realign;
    logic byte_align;
    logic [ldm_pkg::RX_BUF_DEPTH-1:0] fill;
    logic [ldm_pkg::RX_BUF_DEPTH-1:0] next_fill;
    logic tx_ext_result_fresh;
    logic [ldm_pkg::TX_EXT_W-1:0] tx_ext_latency;
    logic rx_ext_result_fresh;
    logic [ldm_pkg::RX_BUF_DEPTH-1:0] rx_ext_latency;
    logic [ldm_pkg::LOOP_W-1:0] loop_latency;
    logic [ldm_pkg::LOOP_W-1:0] loop_result;
    logic loop_done;
    logic tx_frame;
    logic rx_frame;
    logic [ldm_pkg::IRQ_W-1:0] irq_status;
    logic [ldm_pkg::IRQ_W-1:0] irq_mask;
    logic [ldm_pkg::IRQ_W-1:0] irq_events;
    logic [ldm_pkg::IRQ_W-1:0] irq_clear;
    logic [ldm_pkg::DATA_W-1:0] rd_mux;
    logic tx_fresh_clear;
    logic rx_fresh_clear;

    function automatic logic addr_mapped(input logic [ldm_pkg::ADDR_W-1:0] a);
        addr_mapped = (a == ldm_pkg::ADDR_RX_LATENCY) || (a == ldm_pkg::ADDR_TX_EXT) ||
            (a == ldm_pkg::ADDR_RX_EXT) || (a == ldm_pkg::ADDR_LOOP) ||
            (a == ldm_pkg::ADDR_IRQ_STATUS) || (a == ldm_pkg::ADDR_IRQ_MASK);
    endfunction

    assign addr = apb_req.paddr;
    assign wdata = apb_req.pwdata;
    assign setup = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable;
    assign wr = access & apb_req.pwrite & addr_mapped(addr);
    assign rd_setup = setup & ~apb_req.pwrite;
    assign rd_access = access & ~apb_req.pwrite;
    // read data is latched in setup, so every access ends in its first cycle
    assign pready = 1'b1;
    assign pslverr = access & ~addr_mapped(addr);

    ldm_sync u_tx_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in(aux_tx_frame),
        .level(tx_frame)
    );

    ldm_sync u_rx_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in(aux_rx_frame),
        .level(rx_frame)
    );

    ldm_loop_counter u_loop (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .tx_frame(tx_frame),
        .rx_frame(rx_frame),
        .result(loop_result),
        .done(loop_done)
    );

    // control fields; reserved bits of the written word are dropped
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            rx_pointer_realign <= 1'b0;
            tx_integration_span <= ldm_pkg::SPAN_RESET;
            rx_integration_span <= ldm_pkg::SPAN_RESET;
            irq_mask <= ldm_pkg::IRQ_RESET;
        end
        else if (wr)
        begin
            if (addr == ldm_pkg::ADDR_RX_LATENCY)
                rx_pointer_realign <= wdata[ldm_pkg::REALIGN_BIT];
            else if (addr == ldm_pkg::ADDR_TX_EXT)
                tx_integration_span <= wdata[ldm_pkg::SPAN_LSB +: ldm_pkg::SPAN_W];
            else if (addr == ldm_pkg::ADDR_RX_EXT)
                rx_integration_span <= wdata[ldm_pkg::SPAN_LSB +: ldm_pkg::SPAN_W];
            else if (addr == ldm_pkg::ADDR_IRQ_MASK)
                irq_mask <= wdata[ldm_pkg::IRQ_W-1:0];
        end
    end

    // buffer contents are not protected across a resync
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            rx_ptr_resync <= 1'b0;
        else
            rx_ptr_resync <= rx_pointer_realign | rate_change;
    end

    always_comb
    begin
        if (rx_fill_level > {1'b0, ldm_pkg::FILL_MAX})
            next_fill = ldm_pkg::FILL_MAX;
        else
            next_fill = rx_fill_level[ldm_pkg::RX_BUF_DEPTH-1:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            byte_align <= 1'b0;
            fill <= '0;
        end
        else
        begin
            byte_align <= rx_byte_align;
            fill <= next_fill;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            tx_ext_latency <= '0;
            rx_ext_latency <= '0;
            loop_latency <= '0;
        end
        else
        begin
            if (tx_result.strobe)
                tx_ext_latency <= tx_result.value;
            if (rx_result.strobe)
                rx_ext_latency <= rx_result.value[ldm_pkg::RX_BUF_DEPTH-1:0];
            if (loop_done)
                loop_latency <= loop_result;
        end
    end

    // only a flag that the latched read word showed is cleared, so a
    // result landing between setup and access stays visible only if the latched word showed the flag clear
    assign tx_fresh_clear = rd_access && (addr == ldm_pkg::ADDR_TX_EXT) &&
        prdata[ldm_pkg::FRESH_BIT];
    assign rx_fresh_clear = rd_access && (addr == ldm_pkg::ADDR_RX_EXT) &&
        prdata[ldm_pkg::FRESH_BIT];

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            tx_ext_result_fresh <= 1'b0;
            rx_ext_result_fresh <= 1'b0;
        end
        else
        begin
            tx_ext_result_fresh <= tx_result.strobe | (tx_ext_result_fresh & ~tx_fresh_clear);
            rx_ext_result_fresh <= rx_result.strobe | (rx_ext_result_fresh & ~rx_fresh_clear);
        end
    end

    assign irq_events = {rate_change, loop_done, rx_result.strobe, tx_result.strobe};
    assign irq_clear = (wr && addr == ldm_pkg::ADDR_IRQ_STATUS) ?
        wdata[ldm_pkg::IRQ_W-1:0] : ldm_pkg::IRQ_RESET;

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            irq_status <= ldm_pkg::IRQ_RESET;
        else
            irq_status <= (irq_status & ~irq_clear) | irq_events;
    end

    assign irq = |(irq_status & irq_mask);

    always_comb
    begin
        rd_mux = ldm_pkg::ZERO_WORD;
        if (addr == ldm_pkg::ADDR_RX_LATENCY)
        begin
            rd_mux[ldm_pkg::REALIGN_BIT] = rx_pointer_realign;
            rd_mux[ldm_pkg::BYTE_ALIGN_BIT] = byte_align;
            rd_mux[ldm_pkg::RX_BUF_DEPTH-1:0] = fill;
        end
        else if (addr == ldm_pkg::ADDR_TX_EXT)
        begin
            rd_mux[ldm_pkg::SPAN_LSB +: ldm_pkg::SPAN_W] = tx_integration_span;
            rd_mux[ldm_pkg::FRESH_BIT] = tx_ext_result_fresh;
            rd_mux[ldm_pkg::TX_EXT_W-1:0] = tx_ext_latency;
        end
        else if (addr == ldm_pkg::ADDR_RX_EXT)
        begin
            rd_mux[ldm_pkg::SPAN_LSB +: ldm_pkg::SPAN_W] = rx_integration_span;
            rd_mux[ldm_pkg::FRESH_BIT] = rx_ext_result_fresh;
            rd_mux[ldm_pkg::RX_BUF_DEPTH-1:0] = rx_ext_latency;
        end
        else if (addr == ldm_pkg::ADDR_LOOP)
            rd_mux[ldm_pkg::LOOP_W-1:0] = loop_latency;
        else if (addr == ldm_pkg::ADDR_IRQ_STATUS)
            rd_mux[ldm_pkg::IRQ_W-1:0] = irq_status;
        else if (addr == ldm_pkg::ADDR_IRQ_MASK)
            rd_mux[ldm_pkg::IRQ_W-1:0] = irq_mask;
    end

    // unmapped reads give zero along with pslverr; reserved bits stay zero
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            prdata <= ldm_pkg::ZERO_WORD;
        else if (rd_setup)
            prdata <= rd_mux;
    end

    property p_realign_drives;
        @(posedge sys_clk) disable iff (!rst_b)
        rx_pointer_realign |=> rx_ptr_resync;
    endproperty
    a_realign_drives: assert property (p_realign_drives)
        else $error("realign bit did not force resync");

    property p_rate_resync;
        @(posedge sys_clk) disable iff (!rst_b)
        rate_change && !rx_pointer_realign |=> rx_ptr_resync && irq_status[ldm_pkg::IRQ_RESYNC];
    endproperty
    a_rate_resync: assert property (p_rate_resync)
        else $error("rate change did not resync on its own");

    property p_byte_align_read;
        @(posedge sys_clk) disable iff (!rst_b)
        rd_setup && addr == ldm_pkg::ADDR_RX_LATENCY |=>
            prdata[ldm_pkg::BYTE_ALIGN_BIT] == $past(byte_align);
    endproperty
    a_byte_align_read: assert property (p_byte_align_read)
        else $error("byte alignment bit read wrong");

    property p_fill_sat;
        @(posedge sys_clk) disable iff (!rst_b)
        rst_b |=> (fill == (($past(rx_fill_level) > {1'b0, ldm_pkg::FILL_MAX}) ?
            ldm_pkg::FILL_MAX : $past(rx_fill_level[ldm_pkg::RX_BUF_DEPTH-1:0])));
    endproperty
    a_fill_sat: assert property (p_fill_sat)
        else $error("fill level not saturated");

    property p_tx_fresh;
        @(posedge sys_clk) disable iff (!rst_b)
        tx_result.strobe |=> tx_ext_result_fresh && tx_ext_latency == $past(tx_result.value);
    endproperty
    a_tx_fresh: assert property (p_tx_fresh)
        else $error("tx result not stored with fresh flag");

    property p_tx_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        tx_fresh_clear && !tx_result.strobe |=> !tx_ext_result_fresh;
    endproperty
    a_tx_clear: assert property (p_tx_clear)
        else $error("tx fresh flag not cleared by read");

    property p_tx_hold;
        @(posedge sys_clk) disable iff (!rst_b)
        !tx_result.strobe |=> $stable(tx_ext_latency);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("tx result changed without strobe");

    property p_rx_fresh;
        @(posedge sys_clk) disable iff (!rst_b)
        rx_result.strobe |=> rx_ext_result_fresh &&
            rx_ext_latency == $past(rx_result.value[ldm_pkg::RX_BUF_DEPTH-1:0]);
    endproperty
    a_rx_fresh: assert property (p_rx_fresh)
        else $error("rx result not stored with fresh flag");

    property p_rx_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        rx_fresh_clear && !rx_result.strobe |=> !rx_ext_result_fresh;
    endproperty
    a_rx_clear: assert property (p_rx_clear)
        else $error("rx fresh flag not cleared by read");

    property p_loop_update;
        @(posedge sys_clk) disable iff (!rst_b)
        loop_done |=> loop_latency == $past(loop_result) && irq_status[ldm_pkg::IRQ_LOOP];
    endproperty
    a_loop_update: assert property (p_loop_update)
        else $error("loop latency not refreshed");

    property p_loop_frame;
        @(posedge sys_clk) disable iff (!rst_b)
        !loop_done |=> $stable(loop_latency);
    endproperty
    a_loop_frame: assert property (p_loop_frame)
        else $error("loop latency changed outside a frame");

    property p_reserved_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        rd_setup && addr == ldm_pkg::ADDR_LOOP |=> prdata[ldm_pkg::DATA_W-1:ldm_pkg::LOOP_W] == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_irq_level;
        @(posedge sys_clk) disable iff (!rst_b)
        tx_result.strobe && irq_mask[ldm_pkg::IRQ_TX] && !wr |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("unmasked event gave no interrupt");

    c_tx_read: cover property (@(posedge sys_clk) disable iff (!rst_b)
        tx_result.strobe ##[1:20] tx_fresh_clear);
    c_loop: cover property (@(posedge sys_clk) disable iff (!rst_b) loop_done);
    c_rate: cover property (@(posedge sys_clk) disable iff (!rst_b) rate_change ##2 irq);
    c_bad_addr: cover property (@(posedge sys_clk) disable iff (!rst_b) pslverr);
endmodule

/* testbench/ldm_regs_tb.sv */
// self-checking bench for the link latency register bank
// assumes ldm_regs with zero-wait apb, all datapath inputs driven here on sys_clk
`timescale 1ns/1ps
module ldm_regs_tb;
    typedef struct packed {
        logic [7:0] paddr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic err;
    } ldm_tb_row_type;

    logic sys_clk;
    logic rst_b;
    ldm_pkg::ldm_apb_req_type apb_req;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] rx_fill_level;
    logic rx_byte_align;
    logic rate_change;
    ldm_pkg::ldm_ext_result_type tx_result;
    ldm_pkg::ldm_ext_result_type rx_result;
    logic aux_tx_frame;
    logic aux_rx_frame;
    logic rx_ptr_resync;
    logic [7:0] tx_integration_span;
    logic [7:0] rx_integration_span;
    logic irq;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] rdv;
    logic erv;
    logic [4:0] fills [5] = '{5'h00, 5'h09, 5'h0f, 5'h10, 5'h1f};
    ldm_tb_row_type rows [9] = '{
        '{8'h4c, 32'hffff_ffff, 32'h0100_0000, 1'b0},
        '{8'h4c, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{8'h50, 32'hffff_ffff, 32'hff00_0000, 1'b0},
        '{8'h54, 32'ha5ff_ffff, 32'ha500_0000, 1'b0},
        '{8'h58, 32'hffff_ffff, 32'h0000_0000, 1'b0},
        '{8'h74, 32'hffff_ffff, 32'h0000_000f, 1'b0},
        '{8'h70, 32'hffff_ffff, 32'h0000_0000, 1'b0},
        '{8'h60, 32'hffff_ffff, 32'h0000_0000, 1'b1},
        '{8'h00, 32'h1234_5678, 32'h0000_0000, 1'b1}};

    ldm_regs dut (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .apb_req(apb_req),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rx_fill_level(rx_fill_level),
        .rx_byte_align(rx_byte_align),
        .rate_change(rate_change),
        .tx_result(tx_result),
        .rx_result(rx_result),
        .aux_tx_frame(aux_tx_frame),
        .aux_rx_frame(aux_rx_frame),
        .rx_ptr_resync(rx_ptr_resync),
        .tx_integration_span(tx_integration_span),
        .rx_integration_span(rx_integration_span),
        .irq(irq)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // zero wait states are promised, but the master still waits on pready
    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge sys_clk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.paddr <= a;
        apb_req.pwrite <= wr;
        apb_req.pwdata <= d;
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, rdv, erv);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0000_0000, rdv, erv);
        check(rdv, exp);
    endtask

    // tx rise, then rx rise d cycles later; pulses kept 4 cycles for the pin synchronisers
    task automatic frame(input int d);
        @(posedge sys_clk);
        aux_tx_frame <= 1'b1;
        repeat (4) @(posedge sys_clk);
        aux_tx_frame <= 1'b0;
        repeat (d - 4) @(posedge sys_clk);
        aux_rx_frame <= 1'b1;
        repeat (4) @(posedge sys_clk);
        aux_rx_frame <= 1'b0;
        repeat (12) @(posedge sys_clk);
    endtask

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            fails++;
            give_verdict();
        end
    end

    initial
    begin
        rst_b = 1'b0;
        apb_req = '0;
        rx_fill_level = 5'h00;
        rx_byte_align = 1'b0;
        rate_change = 1'b0;
        tx_result = '0;
        rx_result = '0;
        aux_tx_frame = 1'b0;
        aux_rx_frame = 1'b0;
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        check({29'h0, irq, rx_ptr_resync, pready}, 32'h0000_0001);
        rd_chk(8'h4c, 32'h0000_0000);
        rd_chk(8'h50, 32'h0000_0000);
        rd_chk(8'h54, 32'h0000_0000);
        rd_chk(8'h58, 32'h0000_0000);
        rd_chk(8'h70, 32'h0000_0000);
        rd_chk(8'h74, 32'h0000_0000);
        foreach (rows[i])
        begin
            wr(rows[i].paddr, rows[i].wdata);
            apb(rows[i].paddr, 1'b0, 32'h0000_0000, rdv, erv);
            check(rdv, rows[i].rdata);
            check({31'h0, erv}, {31'h0, rows[i].err});
        end
        check({tx_integration_span, rx_integration_span}, 32'h0000_ffa5);
        // fill level saturation, with byte alignment alternating
        foreach (fills[i])
        begin
            @(posedge sys_clk);
            rx_fill_level <= fills[i];
            rx_byte_align <= i[0];
            rd_chk(8'h4c, {15'h0, i[0], 11'h0, (fills[i] > 5'h0f) ? 5'h0f : fills[i]});
        end
        // realign is a level: resync follows one cycle after the write lands
        check({31'h0, rx_ptr_resync}, 32'h0000_0000);
        wr(8'h4c, 32'h0100_0000);
        repeat (2) @(posedge sys_clk);
        check({31'h0, rx_ptr_resync}, 32'h0000_0001);
        repeat (3) @(posedge sys_clk);
        check({31'h0, rx_ptr_resync}, 32'h0000_0001);
        wr(8'h4c, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        check({31'h0, rx_ptr_resync}, 32'h0000_0000);
        // rate change resyncs without the realign bit
        @(posedge sys_clk);
        rate_change <= 1'b1;
        @(posedge sys_clk);
        rate_change <= 1'b0;
        @(posedge sys_clk);
        check({30'h0, rx_ptr_resync, irq}, 32'h0000_0003);
        @(posedge sys_clk);
        check({31'h0, rx_ptr_resync}, 32'h0000_0000);
        // back-to-back tx strobes: the later value is the one kept
        @(posedge sys_clk);
        tx_result <= '{1'b1, 16'h1111};
        @(posedge sys_clk);
        tx_result <= '{1'b1, 16'hbeef};
        rx_result <= '{1'b1, 16'h0abc};
        @(posedge sys_clk);
        tx_result <= '0;
        rx_result <= '0;
        rd_chk(8'h50, 32'hff80_beef);
        rd_chk(8'h50, 32'hff00_beef);
        rd_chk(8'h54, 32'ha580_000c);
        rd_chk(8'h54, 32'ha500_000c);
        frame(20);
        rd_chk(8'h58, 32'h0000_0014);
        frame(9);
        rd_chk(8'h58, 32'h0000_0009);
        // interrupt: all four events latched, then mask and clear
        rd_chk(8'h70, 32'h0000_000f);
        wr(8'h74, 32'h0000_0000);
        @(posedge sys_clk);
        check({31'h0, irq}, 32'h0000_0000);
        wr(8'h74, 32'h0000_0004);
        @(posedge sys_clk);
        check({31'h0, irq}, 32'h0000_0001);
        wr(8'h70, 32'h0000_0005);
        rd_chk(8'h70, 32'h0000_000a);
        check({31'h0, irq}, 32'h0000_0000);
        wr(8'h70, 32'h0000_000a);
        rd_chk(8'h70, 32'h0000_0000);
        // mid-run reset must drop realign, spans, mask and latched results
        wr(8'h4c, 32'h0100_0000);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        check({tx_integration_span, rx_integration_span, 15'h0, rx_ptr_resync}, 32'h0000_0000);
        rd_chk(8'h50, 32'h0000_0000);
        rd_chk(8'h58, 32'h0000_0000);
        rd_chk(8'h74, 32'h0000_0000);
        give_verdict();
    end
endmodule
